// ### eac_map.svh
/*
  register offsets, field positions, reset values and timing counts of the
  eeprom access controller. assumes inclusion by the timer and controller modules.
*/
`ifndef EAC_MAP_SVH
`define EAC_MAP_SVH

`define EAC_IO_TO_DATA_OFS   8'h20
`define EAC_IO_TOP           8'h3F
`define EAC_BIT_IO_TOP       8'h1F
`define EAC_EXT_IO_LO        8'h60

`define EAC_CTRL_ADDR        8'h3F
`define EAC_DATA_ADDR        8'h40
`define EAC_ADRL_ADDR        8'h41
`define EAC_ADRH_ADDR        8'h42

`define EAC_CTRL_RESET       8'h00
`define EAC_DATA_RESET       8'h00
`define EAC_MODE_RESET       2'h0

`define EAC_BIT_RSTB         0
`define EAC_BIT_WSTB         1
`define EAC_BIT_ARM          2
`define EAC_BIT_RIE          3
`define EAC_BIT_MODE_LO      4
`define EAC_BIT_MODE_HI      5

`define EAC_ARM_CYCLES       3'h4
`define EAC_READ_STALL       3'h4
`define EAC_WRITE_STALL      3'h2

`define EAC_T_ATOMIC_US      3400
`define EAC_T_SPLIT_US       1800
`define EAC_RC_HZ            8000000

`endif

// ### eac_pkg.sv
/*
  types of the eeprom access controller.
  assumes eac_map.svh is on the include path.
*/
package eac_pkg;
  typedef enum logic [1:0] {
    EAC_MODE_ATOMIC = 2'h0,
    EAC_MODE_ERASE  = 2'h1,
    EAC_MODE_WRITE  = 2'h2,
    EAC_MODE_RSVD   = 2'h3
  } eac_mode_t;

  typedef enum logic [2:0] {
    EAC_ST_IDLE = 3'h1,
    EAC_ST_ARM  = 3'h2,
    EAC_ST_PROG = 3'h4
  } eac_state_t;
endpackage

// ### eac_prog_timer.sv
/*
  programming duration counter, counted on one-cycle ticks of the calibrated
  oscillator. assumes tick_i is a one-cycle pulse synchronous to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eac_map.svh"

module eac_prog_timer
  import eac_pkg::*;
#(
  parameter int unsigned ATOMIC_TICKS = (`EAC_T_ATOMIC_US * (`EAC_RC_HZ / 1000000)),
  parameter int unsigned SPLIT_TICKS  = (`EAC_T_SPLIT_US * (`EAC_RC_HZ / 1000000))
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       start_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       tick_i,
  output logic            done_o
);
  logic [15:0] count_r;
  logic        run_r;

  // load the mode's duration, count down on ticks, pulse done at zero [R11] [R24]
  // a reset while counting lets the running operation finish [R13]
  always_ff @(posedge clk_i) begin
    if (reset_n_i || run_r) begin
      done_o <= 1'b0;
      if (start_i) begin
        run_r <= 1'b1;
        if (mode_i == EAC_MODE_ERASE || mode_i == EAC_MODE_WRITE) begin
          count_r <= SPLIT_TICKS[15:0];
        end else begin
          count_r <= ATOMIC_TICKS[15:0];
        end
      end else if (run_r && tick_i) begin
        if (count_r <= 16'h0001) begin
          run_r  <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count_r <= count_r - 16'h0001;
        end
      end
    end else begin
      count_r <= 16'h0000;
      run_r   <= 1'b0;
      done_o  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### eac_ctrl.sv
/*
  eeprom access controller: address, data and control registers on the cpu
  io bus, write arming, read fetch, programming sequence and ready request.
  assumes a cpu that issues one io access per cycle, an array that answers
  reads combinationally, and a tick from the calibrated oscillator divider.
*/
`timescale 1ns/10ps
`default_nettype none
`include "eac_map.svh"

// Summary of operation
// R1: port addresses 0x00-0x3F map to data space at port plus 0x20.
// R2: ports 0x00-0x1F accept single-bit set, clear and skip tests.
// R3: extended locations 0x60-0xFF answer data-space accesses only.
// R4: bit set or clear changes only the addressed bit.
// R5: software writes reserved bits as zero, never writes reserved addresses.
// R6: ten-bit byte address from high bits 1:0 and low byte, linear.
// R7: small array: software writes address bits nine and eight as zero.
// R8: byte address is undefined after reset; software loads it first.
// R9: data byte is written to array, or receives the array byte on read.
// R10: action 00 erase+write, 01 erase, 10 write, 11 reserved.
// R11: atomic takes 3.4 ms, erase-only or write-only 1.8 ms.
// R12: action field writes ignored while write strobe set.
// R13: reset clears action field unless programming is in progress.
// R14: ready request is a level while write strobe clear and enabled.
// R15: ready request off during eeprom write and flash self-programming.
// R16: strobe within four cycles of arm starts programming.
// R17: strobe with arm clear starts nothing.
// R18: arm clears by hardware four cycles after being set.
// R19: software sets arm with strobe zero, then strobe within four cycles.
// R20: hardware clears write strobe when programming time elapses.
// R21: read strobe fetches byte at once and stalls cpu four cycles.
// R22: during a write, reads are blocked and address changes refused.
// R23: reserved action 11 runs as the atomic operation.
// R24: duration counted on calibrated oscillator ticks; strobe clears at end.
module eac_ctrl
  import eac_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       io_space_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       bit_set_i,
  input  wire logic       bit_clr_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       global_irq_enable_i,
  input  wire logic       self_program_busy_i,
  input  wire logic       rc_tick_i,
  input  wire logic [7:0] array_rdata_i,
  output logic      [7:0] rdata_o,
  output logic            bit_test_o,
  output logic            hit_o,
  output logic            cpu_stall_o,
  output logic            ready_irq_o,
  output logic      [9:0] array_addr_o,
  output logic      [7:0] array_wdata_o,
  output logic            array_rd_o,
  output logic            array_erase_o,
  output logic            array_write_o
);
  logic [1:0]  mode_r;
  logic        rie_r;
  logic        arm_r;
  logic        wstb_r;
  logic [7:0]  data_r;
  logic [7:0]  adrl_r;
  logic [1:0]  adrh_r;
  logic [2:0]  arm_cnt_r;
  logic [2:0]  stall_cnt_r;
  eac_state_t  state_r;
  logic        prog_done;
  logic        prog_start;
  logic        bit_op;
  logic        reg_access;
  logic [7:0]  daddr;
  logic [7:0]  ctrl_view;
  logic [7:0]  cur_val;
  logic [7:0]  new_val;
  logic        sel_ctrl;
  logic        sel_data;
  logic        sel_adrl;
  logic        sel_adrh;
  logic        wr_eff;
  logic        ctrl_wr;
  logic        read_req;
  logic        arm_req;

  // port accesses shift up by 0x20 into data space; above 0x3F ports do not exist [R1] [R3]
  always_comb begin
    daddr      = io_space_i ? (addr_i + `EAC_IO_TO_DATA_OFS) : addr_i;
    reg_access = io_space_i ? (addr_i <= `EAC_IO_TOP) : 1'b1;
    // bit ops exist only for port addresses 0x00-0x1F [R2]
    bit_op     = io_space_i && (addr_i <= `EAC_BIT_IO_TOP) && (bit_set_i || bit_clr_i);
    sel_ctrl   = reg_access && (daddr == `EAC_CTRL_ADDR);
    sel_data   = reg_access && (daddr == `EAC_DATA_ADDR);
    sel_adrl   = reg_access && (daddr == `EAC_ADRL_ADDR);
    sel_adrh   = reg_access && (daddr == `EAC_ADRH_ADDR);
  end

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[`EAC_BIT_MODE_HI:`EAC_BIT_MODE_LO] = mode_r;
    ctrl_view[`EAC_BIT_RIE]  = rie_r;
    ctrl_view[`EAC_BIT_ARM]  = arm_r;
    ctrl_view[`EAC_BIT_WSTB] = wstb_r;
    cur_val = 8'h00;
    if (sel_ctrl) begin
      cur_val = ctrl_view;
    end else if (sel_data) begin
      cur_val = data_r;
    end else if (sel_adrl) begin
      cur_val = adrl_r;
    end else if (sel_adrh) begin
      cur_val = {6'h00, adrh_r};
    end
    // a bit op rewrites only the addressed bit; the read strobe reads as zero [R4]
    new_val = wdata_i;
    wr_eff  = wr_i;
    if (bit_op) begin
      new_val = cur_val;
      new_val[bit_sel_i] = bit_set_i;
      wr_eff  = 1'b1;
    end
  end

  // control register write, read and arm requests; start is decoded below, action and enable writes decode sel_ctrl themselves
  always_comb begin
    ctrl_wr  = sel_ctrl && wr_eff;
    read_req = ctrl_wr && new_val[`EAC_BIT_RSTB] && !wstb_r;
    arm_req  = ctrl_wr && new_val[`EAC_BIT_ARM] && !new_val[`EAC_BIT_WSTB] && !wstb_r;
  end

  // strobe with arm set starts programming; without arm nothing happens [R16] [R17]
  assign prog_start = ctrl_wr && new_val[`EAC_BIT_WSTB] && !wstb_r && arm_r;

  eac_prog_timer u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .start_i   (prog_start),
    .mode_i    (mode_r),
    .tick_i    (rc_tick_i),
    .done_o    (prog_done)
  );

  // sequencer: idle, armed, programming
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= EAC_ST_IDLE;
    end else begin
      case (state_r)
        EAC_ST_IDLE: begin
          if (arm_req) begin
            state_r <= EAC_ST_ARM;
          end
        end
        EAC_ST_ARM: begin
          if (prog_start) begin
            state_r <= EAC_ST_PROG;
          end else if (!arm_r) begin
            state_r <= EAC_ST_IDLE;
          end
        end
        EAC_ST_PROG: begin
          if (prog_done) begin
            state_r <= EAC_ST_IDLE;
          end
        end
        default: state_r <= EAC_ST_IDLE;
      endcase
    end
  end

  // arm is set with strobe zero and self-clears after four cycles [R18] [R19]
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      arm_r     <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (arm_req) begin
      arm_r     <= 1'b1;
      arm_cnt_r <= `EAC_ARM_CYCLES - 3'h1;
    end else if (arm_r) begin
      if (arm_cnt_r == 3'h0 || prog_start) begin
        arm_r <= 1'b0;
      end else begin
        arm_cnt_r <= arm_cnt_r - 3'h1;
      end
    end
  end

  // write strobe set by an armed start, cleared when the timer ends [R20] [R24]
  // a reset during programming leaves the strobe up until the write completes [R13]
  always_ff @(posedge clk_i) begin
    if (reset_n_i || wstb_r) begin
      if (prog_start) begin
        wstb_r <= 1'b1;
      end else if (prog_done) begin
        wstb_r <= 1'b0;
      end
    end else begin
      wstb_r <= 1'b0;
    end
  end

  // action field: held during a write and through reset while busy [R12] [R13]
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      if (!wstb_r) begin
        mode_r <= `EAC_MODE_RESET;
      end
    end else if (sel_ctrl && wr_eff && !wstb_r) begin
      mode_r <= new_val[`EAC_BIT_MODE_HI:`EAC_BIT_MODE_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rie_r <= 1'b0;
    end else if (sel_ctrl && wr_eff) begin
      rie_r <= new_val[`EAC_BIT_RIE];
    end
  end

  // address is left uninitialised by reset and frozen while writing [R6] [R8] [R22]
  always_ff @(posedge clk_i) begin
    if (!wstb_r && wr_eff && sel_adrl) begin
      adrl_r <= new_val;
    end
    if (!wstb_r && wr_eff && sel_adrh) begin
      adrh_r <= new_val[1:0];
    end
  end

  // data byte: cpu writes, or the array byte on a read strobe [R9] [R21] [R22]
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      data_r <= `EAC_DATA_RESET;
    end else if (read_req) begin
      data_r <= array_rdata_i;
    end else if (sel_data && wr_eff) begin
      data_r <= new_val;
    end
  end

  // cpu stall: four cycles after a read, two after a write start [R21]
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stall_cnt_r <= 3'h0;
      cpu_stall_o <= 1'b0;
    end else if (read_req) begin
      stall_cnt_r <= `EAC_READ_STALL - 3'h1;
      cpu_stall_o <= 1'b1;
    end else if (prog_start) begin
      stall_cnt_r <= `EAC_WRITE_STALL - 3'h1;
      cpu_stall_o <= 1'b1;
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end else begin
      cpu_stall_o <= 1'b0;
    end
  end

  // read data and bit test answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_o    <= 8'h00;
      bit_test_o <= 1'b0;
      hit_o      <= 1'b0;
    end else begin
      rdata_o    <= rd_i ? cur_val : 8'h00;
      bit_test_o <= io_space_i && (addr_i <= `EAC_BIT_IO_TOP) && cur_val[bit_sel_i]; // [R2]
      hit_o      <= (rd_i || wr_i || bit_op) && (sel_ctrl || sel_data || sel_adrl || sel_adrh);
    end
  end

  // ready request is a level: enabled, strobe clear, no flash programming [R14] [R15]
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ready_irq_o <= 1'b0;
    end else begin
      ready_irq_o <= rie_r && global_irq_enable_i && !wstb_r && !prog_start && !self_program_busy_i;
    end
  end

  // array command; reserved action 11 runs as atomic [R10] [R23]
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      array_addr_o  <= 10'h000;
      array_wdata_o <= 8'h00;
      array_rd_o    <= 1'b0;
      array_erase_o <= 1'b0;
      array_write_o <= 1'b0;
    end else begin
      array_addr_o  <= {adrh_r, adrl_r};
      array_wdata_o <= data_r;
      array_rd_o    <= read_req;
      array_erase_o <= prog_start && (mode_r != EAC_MODE_WRITE);
      array_write_o <= prog_start && (mode_r != EAC_MODE_ERASE);
    end
  end
endmodule
`default_nettype wire

// ### eac_array_model.sv
/*
  eeprom array model: byte store with a combinational read port.
  assumes one-cycle erase and write pulses on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module eac_array_model (
  input  wire logic       clk_i,
  input  wire logic [9:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       erase_i,
  input  wire logic       write_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [1024];
  // erase leaves ones, write stores the byte
  always_ff @(posedge clk_i) begin
    if (write_i)
      mem[addr_i] <= wdata_i;
    else if (erase_i)
      mem[addr_i] <= 8'hFF;
  end
  assign rdata_o = mem[addr_i];
endmodule
`default_nettype wire

// ### eac_ctrl_assertions.sv
/*
  port checks of eac_ctrl.
  assumes binding to the eac_ctrl top.
*/
`timescale 1ns/10ps
`default_nettype none
module eac_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       io_space_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic       global_irq_enable_i,
  input wire logic       self_program_busy_i,
  input wire logic       hit_o,
  input wire logic       cpu_stall_o,
  input wire logic       ready_irq_o,
  input wire logic [9:0] array_addr_o,
  input wire logic       array_rd_o,
  input wire logic       array_erase_o,
  input wire logic       array_write_o
);
  logic [2:0] arm_age_r;
  logic       ctl_w;
  logic       go;
  assign ctl_w = wr_i && addr_i == (io_space_i ? 8'h1F : 8'h3F);
  assign go = array_write_o || array_erase_o;
  // cycles since the arm bit was written, saturating
  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      arm_age_r <= 3'h7;
    else if (ctl_w && wdata_i[2])
      arm_age_r <= 3'h0;
    else if (arm_age_r != 3'h7)
      arm_age_r <= arm_age_r + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_ARM_TIMEOUT: assert property (ctl_w && wdata_i[1] && arm_age_r >= 3'h4 |=> !go [*2])
    else $error("start without live arm");
  AST_PORT_RANGE: assert property ((wr_i || rd_i) && io_space_i && addr_i > 8'h3F |=> !hit_o)
    else $error("port above range decoded");
  AST_IRQ_SPM: assert property (self_program_busy_i && $past(self_program_busy_i) |-> !ready_irq_o)
    else $error("ready request during flash op");
  AST_IRQ_GIE: assert property (!global_irq_enable_i && !$past(global_irq_enable_i) |-> !ready_irq_o)
    else $error("ready request while masked");
  AST_IRQ_BUSY: assert property (go |-> ##2 (!ready_irq_o) [*4])
    else $error("ready request during write");
  AST_RD_BLOCK: assert property (go |=> (!array_rd_o) [*8])
    else $error("array read during write");
  AST_ADDR_HOLD: assert property (go |=> $stable(array_addr_o) [*8])
    else $error("address moved during write");
  AST_STALL: assert property ($rose(cpu_stall_o) |-> cpu_stall_o [*2])
    else $error("stall too short");
  cover property (go);
  cover property (array_rd_o);
  cover property (ready_irq_o);
endmodule
bind eac_ctrl eac_ctrl_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .io_space_i(io_space_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .global_irq_enable_i(global_irq_enable_i),
  .self_program_busy_i(self_program_busy_i), .hit_o(hit_o), .cpu_stall_o(cpu_stall_o),
  .ready_irq_o(ready_irq_o), .array_addr_o(array_addr_o), .array_rd_o(array_rd_o),
  .array_erase_o(array_erase_o), .array_write_o(array_write_o));
`default_nettype wire

// ### tb.sv
/*
  self-checking bench of eac_ctrl with the array model.
  assumes the package and map header compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk_i = 1'b0, rst_n = 1'b0, io = 1'b0, wr = 1'b0, rd = 1'b0;
  logic       bs = 1'b0, bc = 1'b0, gie = 1'b1, self_program_op = 1'b0, tick = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [7:0] a = 8'h00, wd = 8'h00, ard, rdat, awd;
  logic       bt, hit, stall, irq, aro, er, aw;
  logic [9:0] aa;
  int         error_cnt = 0, checked = 0, wcnt = 0, cyc = 0, t0, n;
  int         ticks [3] = '{27200, 14400, 14400};
  logic [24:0] rows [9] = '{{1'b0,8'h40,8'hA5,8'hA5}, {1'b1,8'h20,8'h3C,8'h3C}, {1'b0,8'h41,8'h5A,8'h5A},
    {1'b1,8'h21,8'hC3,8'hC3}, {1'b1,8'h22,8'h02,8'h02}, {1'b0,8'h42,8'h01,8'h01},
    {1'b1,8'h1F,8'h18,8'h18}, {1'b0,8'h3F,8'h28,8'h28}, {1'b1,8'h1F,8'h08,8'h08}};
  always #4 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    cyc++;
    if (aw === 1'b1 || er === 1'b1)
      wcnt++;
  end
  eac_ctrl dut (.clk_i(clk_i), .reset_n_i(rst_n), .io_space_i(io), .addr_i(a), .wr_i(wr), .rd_i(rd),
    .bit_set_i(bs), .bit_clr_i(bc), .bit_sel_i(sel), .wdata_i(wd), .global_irq_enable_i(gie),
    .self_program_busy_i(self_program_op), .rc_tick_i(tick), .array_rdata_i(ard), .rdata_o(rdat), .bit_test_o(bt),
    .hit_o(hit), .cpu_stall_o(stall), .ready_irq_o(irq), .array_addr_o(aa), .array_wdata_o(awd),
    .array_rd_o(aro), .array_erase_o(er), .array_write_o(aw));
  eac_array_model mdl (.clk_i(clk_i), .addr_i(aa), .wdata_i(awd), .erase_i(er), .write_i(aw), .rdata_o(ard));
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(logic i, logic [7:0] ad, d, logic w, r, logic [2:0] s = 3'h0, logic b1 = 1'b0, b0 = 1'b0);
    @(posedge clk_i);
    repeat (8) if (stall === 1'b1) @(posedge clk_i);
    io <= i; a <= ad; wd <= d; wr <= w; rd <= r; sel <= s; bs <= b1; bc <= b0;
    @(posedge clk_i);
    wr <= 1'b0; rd <= 1'b0; bs <= 1'b0; bc <= 1'b0;
    #1;
  endtask
  task automatic wrd(logic i, logic [7:0] ad, d);
    acc(i, ad, d, 1'b1, 1'b0);
  endtask
  task automatic rdc(string nm, logic i, logic [7:0] ad, e);
    acc(i, ad, 8'h00, 1'b0, 1'b1);
    chk(nm, 16'(rdat), 16'(e));
  endtask
  task automatic rst();
    @(posedge clk_i);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n <= 1'b1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n <= 1'b1;
    rdc("ctl_rst", 1'b1, 8'h1F, 8'h00);
    rdc("dat_rst", 1'b0, 8'h40, 8'h00);
    foreach (rows[k]) begin
      wrd(rows[k][24], rows[k][23:16], rows[k][15:8]);
      rdc("row", rows[k][24], rows[k][23:16], rows[k][7:0]);
      chk("hit", 16'(hit), 16'h1);
    end
    $display("table done");
    acc(1'b1, 8'h1F, 8'h00, 1'b0, 1'b0, 3'h5, 1'b1);
    rdc("sbi", 1'b1, 8'h1F, 8'h28);
    acc(1'b1, 8'h1F, 8'h00, 1'b0, 1'b0, 3'h3, 1'b0, 1'b1);
    rdc("cbi", 1'b1, 8'h1F, 8'h20);
    acc(1'b1, 8'h1F, 8'h00, 1'b0, 1'b1, 3'h5);
    chk("skip", 16'(bt), 16'h1);
    acc(1'b1, 8'h1F, 8'h00, 1'b0, 1'b1, 3'h3);
    chk("skip_clr", 16'(bt), 16'h0);
    acc(1'b1, 8'h40, 8'h00, 1'b0, 1'b1);
    chk("hi_port", 16'(hit), 16'h0);
    acc(1'b0, 8'h60, 8'h00, 1'b0, 1'b1);
    chk("ext_io", 16'(hit), 16'h0);
    $display("bit ops done");
    wrd(1'b1, 8'h1F, 8'h0C);
    rdc("arm_on", 1'b1, 8'h1F, 8'h0C);
    repeat (3) @(posedge clk_i);
    rdc("arm_off", 1'b1, 8'h1F, 8'h08);
    wrd(1'b1, 8'h1F, 8'h0A);
    repeat (4) @(posedge clk_i);
    chk("no_start", 16'(wcnt), 16'h0);
    chk("irq_idle", 16'(irq), 16'h1);
    @(posedge clk_i);
    self_program_op <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("irq_spm", 16'(irq), 16'h0);
    @(posedge clk_i);
    self_program_op <= 1'b0;
    gie <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("irq_gie", 16'(irq), 16'h0);
    @(posedge clk_i);
    gie <= 1'b1;
    $display("arm and irq done");
    wrd(1'b0, 8'h41, 8'hAB);
    wrd(1'b0, 8'h42, 8'h02);
    wrd(1'b0, 8'h40, 8'h5C);
    for (int m = 0; m < 3; m++) begin
      wrd(1'b1, 8'h1F, {2'h0, 2'(m), 4'hC});
      wrd(1'b1, 8'h1F, {2'h0, 2'(m), 4'hA});
      t0 = cyc;
      if (m == 0) begin
        wrd(1'b0, 8'h41, 8'h00);
        wrd(1'b1, 8'h1F, 8'h1A);
        acc(1'b1, 8'h1F, 8'h00, 1'b0, 1'b0, 3'h0, 1'b1);
        chk("irq_busy", 16'(irq), 16'h0);
      end
      n = 0;
      while (irq !== 1'b1 && n < 30000) begin
        @(posedge clk_i);
        n++;
      end
      chk("t_prog", 16'(cyc - t0 >= ticks[m] - 2 && cyc - t0 <= ticks[m] + 12), 16'h1);
      rdc("ctl_done", 1'b1, 8'h1F, {2'h0, 2'(m), 4'h8});
      chk("mem", 16'(mdl.mem[10'h2AB]), m == 1 ? 16'h00FF : 16'h005C);
      rdc("adr_kept", 1'b0, 8'h41, 8'hAB);
      $display("mode %0d done", m);
    end
    wrd(1'b1, 8'h1F, 8'h09);
    chk("stall_on", 16'(stall), 16'h1);
    repeat (3) @(posedge clk_i);
    #1 chk("stall_4", 16'(stall), 16'h1);
    @(posedge clk_i);
    #1 chk("stall_end", 16'(stall), 16'h0);
    rdc("rd_byte", 1'b0, 8'h40, 8'h5C);
    wrd(1'b0, 8'h40, 8'hE7);
    wrd(1'b1, 8'h1F, 8'h34);
    wrd(1'b1, 8'h1F, 8'h36);
    rst();
    acc(1'b1, 8'h1F, 8'h00, 1'b0, 1'b1);
    chk("mode_kept", 16'(rdat & 8'h30), 16'h0030);
    n = 0;
    while (rdat[1] !== 1'b0 && n < 20000) begin
      acc(1'b1, 8'h1F, 8'h00, 1'b0, 1'b1);
      n++;
    end
    chk("t_rsvd", 16'(n >= 13000 && n < 13700), 16'h1);
    chk("rsvd_mem", 16'(mdl.mem[10'h2AB]), 16'h00E7);
    rst();
    rdc("mode_rst", 1'b1, 8'h1F, 8'h00);
    $display("reset tests done");
    end_sim();
  end
endmodule
`default_nettype wire
